// ==== fetx_top.v ====
// Purpose: 100 Mb/s transmit encoder from mii nibbles to three-level streams
// Assumes: one clock; nibble taken every five clocks when nib_ready is high
// Notes: the mac holds each nibble until nib_ready
`timescale 1ns/1ns
`include "fetx_regs.vh"
module fetx_top #(
	parameter FIFO_DEPTH = `FETX_FIFO_DEPTH
)(
	input wire clk,
	input wire rst,
	input wire tx_en,
	input wire tx_er,
	input wire [3:0] tx_nibble,
	output wire nib_ready,
	input wire [4:0] strap_address_inputs,
	input wire scr_bypass,
	output wire mlt_pos,
	output wire mlt_neg,
	output wire halt_sent
);
	localparam ST_IDLE = 3'd0;
	localparam ST_K = 3'd1;
	localparam ST_DATA = 3'd2;
	localparam ST_T = 3'd3;
	localparam ST_R = 3'd4;
	reg [2:0] st_ff;
	reg [2:0] nxt_st;
	reg [4:0] cg;
	reg [4:0] strap_ff;
	reg seed_load_ff;
	reg rst_d_ff;
	reg [4:0] strap_s1_ff;
	reg [4:0] strap_s2_ff;
	reg [4:0] strap_s3_ff;
	reg byp_s1_ff;
	reg byp_s2_ff;
	reg byp_s3_ff;
	reg byp_ff;
	wire line_run;
	reg halt_ff;
	reg [4:0] shift_ff;
	reg [2:0] cnt_ff;
	wire fifo_in_ready;
	wire [4:0] fifo_data;
	wire fifo_valid;
	wire fifo_take;
	function [4:0] enc4b5b;
		input [3:0] n;
		begin
			case (n)
			4'h0: enc4b5b = 5'h1E;
			4'h1: enc4b5b = 5'h09;
			4'h2: enc4b5b = 5'h14;
			4'h3: enc4b5b = 5'h15;
			4'h4: enc4b5b = 5'h0A;
			4'h5: enc4b5b = 5'h0B;
			4'h6: enc4b5b = 5'h0E;
			4'h7: enc4b5b = 5'h0F;
			4'h8: enc4b5b = 5'h12;
			4'h9: enc4b5b = 5'h13;
			4'hA: enc4b5b = 5'h16;
			4'hB: enc4b5b = 5'h17;
			4'hC: enc4b5b = 5'h1A;
			4'hD: enc4b5b = 5'h1B;
			4'hE: enc4b5b = 5'h1C;
			default: enc4b5b = 5'h1D;
			endcase
		end
	endfunction
	assign nib_ready = fifo_in_ready && (st_ff == ST_IDLE || st_ff == ST_K || st_ff == ST_DATA);
	always @*
	begin
		nxt_st = st_ff;
		cg = `FETX_CG_IDLE;
		case (st_ff)
		ST_IDLE:
		begin
			if (tx_en)
			begin
				cg = `FETX_CG_J;
				nxt_st = ST_K;
			end
		end
		ST_K:
		begin
			cg = `FETX_CG_K;
			nxt_st = tx_en ? ST_DATA : ST_T;
		end
		ST_DATA:
		begin
			if (tx_en)
				cg = tx_er ? `FETX_CG_HALT : enc4b5b(tx_nibble);
			else
			begin
				cg = `FETX_CG_T;
				nxt_st = ST_R;
			end
		end
		ST_T:
		begin
			cg = `FETX_CG_T;
			nxt_st = ST_R;
		end
		ST_R:
		begin
			cg = `FETX_CG_R;
			nxt_st = ST_IDLE;
		end
		default:
			nxt_st = ST_IDLE;
		endcase
	end
	always @(posedge clk)
	begin
		rst_d_ff <= rst;
		// pin synchronisers, change accepted once stages two and three agree; strap only in the clock after reset ends
		strap_s1_ff <= strap_address_inputs;
		strap_s2_ff <= strap_s1_ff;
		strap_s3_ff <= strap_s2_ff;
		byp_s1_ff <= scr_bypass;
		byp_s2_ff <= byp_s1_ff;
		byp_s3_ff <= byp_s2_ff;
		if (byp_s2_ff == byp_s3_ff)
			byp_ff <= byp_s3_ff;
		if (rst)
		begin
			st_ff <= ST_IDLE;
			halt_ff <= 1'b0;
			strap_ff <= 5'h00;
			seed_load_ff <= 1'b0;
		end
		else
		begin
			seed_load_ff <= rst_d_ff;
			if (rst_d_ff && (strap_s2_ff == strap_s3_ff))
				strap_ff <= strap_s3_ff;
			if (fifo_in_ready)
			begin
				st_ff <= nxt_st;
				halt_ff <= (cg == `FETX_CG_HALT);
			end
			else
				halt_ff <= 1'b0;
		end
	end
	assign halt_sent = halt_ff;
	fetx_fifo #(
		.WIDTH(`FETX_SYM_BITS),
		.DEPTH(FIFO_DEPTH),
		.AW(3)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.in_data(cg),
		.in_valid(1'b1),
		.in_ready(fifo_in_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_take)
	);
	assign fifo_take = (cnt_ff == 3'd0);
	always @(posedge clk)
	begin
		if (rst)
		begin
			shift_ff <= `FETX_CG_IDLE;
			cnt_ff <= 3'd0;
		end
		else if (cnt_ff == 3'd0)
		begin
			shift_ff <= fifo_valid ? fifo_data : `FETX_CG_IDLE;
			cnt_ff <= 3'd4;
		end
		else
		begin
			shift_ff <= {shift_ff[3:0], 1'b0};
			cnt_ff <= cnt_ff - 3'd1;
		end
	end
	// line held quiet until the seed is in place
	assign line_run = !rst_d_ff && !seed_load_ff;
	fetx_line u_line (
		.clk(clk),
		.rst(rst),
		.bit_in(shift_ff[4]),
		.bit_valid(line_run),
		.scr_bypass(byp_ff),
		.seed_load(seed_load_ff),
		.seed({strap_ff[4:1], `FETX_SEED_LOW}),
		.mlt_pos_ff(mlt_pos),
		.mlt_neg_ff(mlt_neg)
	);
endmodule

// ==== fetx_regs.vh ====
// Purpose: constants for the fast ethernet transmit encoder
// Assumes: included by fetx_top, not by the fifo or line files
// Notes: code-groups are sent msb first
`ifndef FETX_REGS_VH
`define FETX_REGS_VH
`define FETX_CG_J 5'h18
`define FETX_CG_K 5'h11
`define FETX_CG_T 5'h0D
`define FETX_CG_R 5'h07
`define FETX_CG_IDLE 5'h1F
`define FETX_CG_HALT 5'h04
`define FETX_SEED_LOW 7'h5A
`define FETX_SYM_BITS 5
`define FETX_FIFO_DEPTH 8
`endif

// ==== fetx_fifo.v ====
// Purpose: code-group buffer between encoder and serializer
// Assumes: single clock, synchronous active high reset
// Notes: depth must be a power of two
`timescale 1ns/1ns
module fetx_fifo #(
	parameter WIDTH = 5,
	parameter DEPTH = 8,
	parameter AW = 3
)(
	input wire clk,
	input wire rst,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0] wr_ff;
	reg [AW:0] rd_ff;
	wire full;
	wire empty;
	assign empty = (wr_ff == rd_ff);
	assign full = (wr_ff[AW-1:0] == rd_ff[AW-1:0]) && (wr_ff[AW] != rd_ff[AW]);
	assign in_ready = ~full;
	assign out_valid = ~empty;
	assign out_data = mem[rd_ff[AW-1:0]];
	always @(posedge clk)
	begin
		if (in_valid && !full)
			mem[wr_ff[AW-1:0]] <= in_data;
	end
	always @(posedge clk)
	begin
		if (rst)
		begin
			wr_ff <= {(AW+1){1'b0}};
			rd_ff <= {(AW+1){1'b0}};
		end
		else
		begin
			if (in_valid && !full)
				wr_ff <= wr_ff + 1'b1;
			if (out_ready && !empty)
				rd_ff <= rd_ff + 1'b1;
		end
	end
endmodule

// ==== fetx_line.v ====
// Purpose: scrambler, nrzi and three-level split on serial bits
// Assumes: one bit per clock when bit_valid is high
// Notes: seed loaded by seed_load
`timescale 1ns/1ns
module fetx_line (
	input wire clk,
	input wire rst,
	input wire bit_in,
	input wire bit_valid,
	input wire scr_bypass,
	input wire seed_load,
	input wire [10:0] seed,
	output reg mlt_pos_ff,
	output reg mlt_neg_ff
);
	reg [10:0] lfsr_ff;
	reg nrzi_ff;
	reg phase_ff;
	wire fb;
	wire scr_bit;
	assign fb = lfsr_ff[10] ^ lfsr_ff[8];
	assign scr_bit = scr_bypass ? bit_in : (bit_in ^ fb);
	always @(posedge clk)
	begin
		if (rst)
		begin
			lfsr_ff <= 11'h7FF;
			nrzi_ff <= 1'b0;
			phase_ff <= 1'b0;
			mlt_pos_ff <= 1'b0;
			mlt_neg_ff <= 1'b0;
		end
		else if (seed_load)
			lfsr_ff <= seed;
		else if (bit_valid)
		begin
			lfsr_ff <= {lfsr_ff[9:0], fb};
			if (scr_bit)
			begin
				nrzi_ff <= ~nrzi_ff;
				phase_ff <= ~phase_ff;
			end
			mlt_pos_ff <= scr_bit && !phase_ff;
			mlt_neg_ff <= scr_bit && phase_ff;
		end
	end
endmodule

// ==== fetx_top_props.sv ====
// Purpose: line stage and halt checks
// Assumes: fetx_top ports only
// Notes: bound at file foot
`timescale 1ns/1ns
module fetx_chk (
	input wire clk,
	input wire rst,
	input wire tx_en,
	input wire tx_er,
	input wire nib_ready,
	input wire scr_bypass,
	input wire mlt_pos,
	input wire mlt_neg,
	input wire halt_sent
);
default clocking @(posedge clk); endclocking
default disable iff (rst);
wire pulse = mlt_pos | mlt_neg;
reg [1:0] last_ff;
reg [6:0] zrun_ff;
always @(posedge clk)
begin
	if (rst)
		last_ff <= 2'h0;
	else if (pulse)
		last_ff <= {mlt_neg, mlt_pos};
	zrun_ff <= pulse ? 7'h00 : zrun_ff + 7'h01;
end
no_both_a: assert property (!(mlt_pos && mlt_neg)) else $error("both");
pos_alt_a: assert property (mlt_pos |-> last_ff != 2'h1) else $error("pos");
neg_alt_a: assert property (mlt_neg |-> last_ff != 2'h2) else $error("neg");
rst_quiet_a: assert property (disable iff (1'b0) rst |=> !pulse && !halt_sent)
	else $error("reset");
wake_quiet_a: assert property ($fell(rst) |-> !pulse [*2]) else $error("wake");
halt_cause_a: assert property (halt_sent |-> $past(tx_er && tx_en && nib_ready))
	else $error("halt");
halt_seen_a: assert property (tx_er && tx_en && nib_ready |=> halt_sent)
	else $error("no halt");
run_limit_a: assert property (scr_bypass && last_ff != 2'h0 |-> zrun_ff < 7'h04)
	else $error("run");
endmodule
bind fetx_top fetx_chk u_chk (.clk(clk), .rst(rst), .tx_en(tx_en), .tx_er(tx_er),
	.nib_ready(nib_ready), .scr_bypass(scr_bypass), .mlt_pos(mlt_pos),
	.mlt_neg(mlt_neg), .halt_sent(halt_sent));

// ==== fetx_mac_model.sv ====
// Purpose: mac feeding nibbles
// Assumes: taken when nib_ready high
// Notes: two preamble nibbles, then 0 up
`timescale 1ns/1ns
module fetx_mac_model (
	input wire clk,
	input wire rst,
	input wire start,
	input wire [5:0] len,
	input wire err,
	input wire nib_ready,
	output wire tx_en,
	output wire tx_er,
	output wire [3:0] tx_nibble
);
reg busy_ff = 1'b0;
reg [5:0] idx_ff = 6'h00;
assign tx_en = busy_ff && (idx_ff < len + 6'h02);
assign tx_er = tx_en && err && (idx_ff == 6'h04);
assign tx_nibble = tx_en ? (idx_ff < 6'h02 ? 4'h5 : idx_ff[3:0] - 4'h2) : ~idx_ff[3:0];
always @(posedge clk)
begin
	if (rst || start)
		idx_ff <= 6'h00;
	else if (busy_ff && nib_ready)
		idx_ff <= idx_ff + 6'h01;
	if (rst)
		busy_ff <= 1'b0;
	else if (start)
		busy_ff <= 1'b1;
	else if (nib_ready && !tx_en)
		busy_ff <= 1'b0;
end
endmodule

// ==== tb_fetx_top.sv ====
// Purpose: bench for fetx_top
// Assumes: mac model on the nibble side
// Notes: frames judged with bypass on
`timescale 1ns/1ns
module tb_fetx_top;
reg clk = 1'b0;
reg rst = 1'b1;
reg [4:0] strap = 5'h02;
reg byp = 1'b1;
reg go = 1'b0;
reg err = 1'b0;
reg [5:0] len = 6'h00;
wire en, er, rdy, mp, mn, hs;
wire [3:0] nib;
wire [79:0] cgt = {5'h1D, 5'h1C, 5'h1B, 5'h1A, 5'h17, 5'h16, 5'h13, 5'h12,
	5'h0F, 5'h0E, 5'h0B, 5'h0A, 5'h15, 5'h14, 5'h09, 5'h1E};
integer failures = 0;
integer samples_checked = 0;
integer cyc = 0;
integer n, i;
reg [63:0] sa, sb, sc;
reg [119:0] ex;
always #10 clk = ~clk;
fetx_top uut (.clk(clk), .rst(rst), .tx_en(en), .tx_er(er), .tx_nibble(nib),
	.nib_ready(rdy), .strap_address_inputs(strap), .scr_bypass(byp),
	.mlt_pos(mp), .mlt_neg(mn), .halt_sent(hs));
fetx_mac_model mac (.clk(clk), .rst(rst), .start(go), .len(len), .err(err),
	.nib_ready(rdy), .tx_en(en), .tx_er(er), .tx_nibble(nib));
task chk(input [63:0] e, input [63:0] g);
begin
	samples_checked = samples_checked + 1;
	if (e !== g)
	begin
		failures = failures + 1;
		$display("wrong value t=%0t exp %h got %h", $time, e, g);
	end
end
endtask
task end_sim;
begin
	$display("failures %0d samples_checked %0d", failures, samples_checked);
	if (failures == 0 && samples_checked > 0)
		$display("== PASSED ==");
	else
		$display("== FAILED ==");
	$finish;
end
endtask
task do_reset(input [4:0] s, input b);
begin
	@(posedge clk);
	rst <= 1'b1;
	strap <= s;
	byp <= b;
	repeat (5) @(posedge clk);
	rst <= 1'b0;
	repeat (120) @(posedge clk);
end
endtask
task frame(input [5:0] l, input e);
begin
	ex = {3'h0, 5'h11};
	n = 8;
	for (i = 0; i < l; i = i + 1)
	begin
		ex = {ex, (e && i == 2) ? 5'h04 : cgt[i*5 +: 5]};
		n = n + 5;
	end
	ex = {ex, 5'h0D, 5'h07, 5'h1F};
	n = n + 15;
	@(posedge clk);
	len <= l;
	err <= e;
	go <= 1'b1;
	@(posedge clk);
	go <= 1'b0;
	i = 0;
	@(negedge clk);
	while ((mp | mn) && i < 300)
	begin
		@(negedge clk);
		i = i + 1;
	end
	for (i = n - 1; i >= 0; i = i - 1)
	begin
		chk(ex[i], mp | mn);
		@(negedge clk);
	end
end
endtask
task cap(input [4:0] s, output [63:0] v);
begin
	do_reset(s, 1'b0);
	for (i = 0; i < 64; i = i + 1)
	begin
		@(negedge clk);
		v = {v[62:0], mp | mn};
	end
end
endtask
task scram;
begin
	cap(5'h02, sa);
	cap(5'h03, sb);
	cap(5'h1E, sc);
	chk(sb, sa);
	chk(1'b1, sa != sc);
	chk(1'b1, sa != 64'hFFFFFFFFFFFFFFFF);
end
endtask
initial
begin
	do_reset(5'h02, 1'b1);
	frame(6'h10, 1'b0);
	frame(6'h04, 1'b1);
	scram;
	do_reset(5'h02, 1'b1);
	frame(6'h03, 1'b0);
	end_sim;
end
always @(posedge clk)
begin
	cyc = cyc + 1;
	if (cyc == 20000)
	begin
		failures = failures + 1;
		end_sim;
	end
end
endmodule
